// ### hw/harb_consts.vh
/*
 Constants shared by the health attribute record builder: attribute
 identifiers, flag words, fixed values, layout versions, record geometry
 and status check codes.
 Assumes inclusion by bare name from files under hw/.
*/
`ifndef HARB_CONSTS_VH
`define HARB_CONSTS_VH

// ---------------------------------------------------------------
// Attribute identifiers
// ---------------------------------------------------------------
`define HARB_ID_SPARE 8'hC4
`define HARB_ID_ERASE 8'hE5
`define HARB_ID_ECC_TOT 8'hCB
`define HARB_ID_ECC_COR 8'hCC
`define HARB_ID_READS 8'hE8
`define HARB_ID_CRC 8'hC7

// ---------------------------------------------------------------
// Flag words and fixed values
// ---------------------------------------------------------------
`define HARB_FLAGS_ADVISORY 16'h0002
`define HARB_FLAGS_PREFAIL 16'h0003
`define HARB_FIXED_VALUE 8'h64
`define HARB_PCT_FULL 8'h64
`define HARB_WORST_RESET 8'hFF
`define HARB_VALUE_RESET 8'h64

// ---------------------------------------------------------------
// Layout versions (value of sector bytes 0..1)
// ---------------------------------------------------------------
`define HARB_VER_EARLY 16'h0004
`define HARB_VER_LATER 16'h0010

// ---------------------------------------------------------------
// Record geometry
// ---------------------------------------------------------------
`define HARB_REC_LEN 4'hC
`define HARB_SLOT_SPARE 3'h0
`define HARB_SLOT_ERASE 3'h1
`define HARB_SLOT_ECC_TOT 3'h2
`define HARB_SLOT_ECC_COR 3'h3
`define HARB_SLOT_READS 3'h4
`define HARB_SLOT_CRC 3'h5
`define HARB_CHIPS 4
`define HARB_CHIP_W 2

// ---------------------------------------------------------------
// Status check codes
// ---------------------------------------------------------------
`define HARB_CYL_LO_BAD 8'hF4
`define HARB_CYL_HI_BAD 8'h2C
`define HARB_CYL_LO_OK 8'h4F
`define HARB_CYL_HI_OK 8'hC2

// ---------------------------------------------------------------
// Divider geometry
// ---------------------------------------------------------------
`define HARB_DIV_STEPS 6'h28

`endif

// ### hw/harb_pct_div.v
/*
 Serial divider giving 100 * num / den as a percentage capped at 100.
 Assumes start is a one-cycle pulse given only while busy is low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "harb_consts.vh"

module harb_pct_div (
   input wire sys_clk,
   input wire rst_n,
   input wire start,
   input wire [31:0] num,
   input wire [31:0] den,
   output wire busy,
   output reg done,
   output reg [7:0] pct
);
   reg [39:0] dvd_q;
   reg [39:0] quo_q;
   reg [32:0] rem_q;
   reg [31:0] den_q;
   reg [5:0] cnt_q;
   wire [32:0] trial;
   wire fits;
   wire [39:0] quo_d;

   assign busy = (cnt_q != 6'h00);
   assign trial = {rem_q[31:0], dvd_q[39]};
   assign fits = (trial >= {1'b0, den_q});
   assign quo_d = {quo_q[38:0], fits};

   // -----------------------------------------------------------
   // Restoring division, one quotient bit per clock
   // -----------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dvd_q <= 40'h0000000000;
         quo_q <= 40'h0000000000;
         rem_q <= 33'h000000000;
         den_q <= 32'h00000000;
         cnt_q <= 6'h00;
         done <= 1'b0;
         pct <= 8'h00;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            dvd_q <= {8'h00, num} * 40'h0000000064;
            quo_q <= 40'h0000000000;
            rem_q <= 33'h000000000;
            den_q <= den;
            cnt_q <= `HARB_DIV_STEPS;
         end else if (busy) begin
            rem_q <= fits ? (trial - {1'b0, den_q}) : trial;
            dvd_q <= {dvd_q[38:0], 1'b0};
            quo_q <= quo_d;
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
               done <= 1'b1;
               // Zero divisor or overflow reads as full
               if (den_q == 32'h00000000 ||
                   quo_d > {32'h00000000, `HARB_PCT_FULL})
                  pct <= `HARB_PCT_FULL;
               else
                  pct <= quo_d[7:0];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### hw/harb_spare_scan.v
/*
 Combinational scan of per-chip spare counts: finds the chip with the
 fewest current spares and the saturated sum of current spares.
 Assumes counts are packed 16 bits per chip, chip 0 lowest.
*/
`timescale 1ns/1ps
`default_nettype none
`include "harb_consts.vh"

module harb_spare_scan (
   input wire [16*`HARB_CHIPS-1:0] init_flat,
   input wire [16*`HARB_CHIPS-1:0] cur_flat,
   output reg [15:0] low_init,
   output reg [15:0] low_cur,
   output reg [15:0] sum_cur
);
   reg [17:0] acc;
   integer i;

   always @* begin
      acc = 18'h00000;
      low_init = init_flat[15:0];
      low_cur = cur_flat[15:0];
      for (i = 0; i < `HARB_CHIPS; i = i + 1) begin
         acc = acc + {2'b00, cur_flat[i*16 +: 16]};
         if (cur_flat[i*16 +: 16] < low_cur) begin
            low_cur = cur_flat[i*16 +: 16];
            low_init = init_flat[i*16 +: 16];
         end
      end
      // Sum is held in two bytes, so it saturates
      sum_cur = (acc[17:16] != 2'b00) ? 16'hFFFF : acc[15:0];
   end
endmodule
`default_nettype wire

// ### hw/harb_builder.v
/*
 Health attribute record builder: computes the spare block and erase
 count attribute values, tracks worst values, serves the 12-byte
 attribute records byte by byte, the spare block record in the later
 layout only and the others in either, and answers the status check
 with the cylinder codes.
 Assumes all inputs synchronous to sys_clk and counters held stable by
 the surrounding firmware logic while a record is read.
*/
`timescale 1ns/1ps
`default_nettype none
`include "harb_consts.vh"

module harb_builder (
   input wire sys_clk,
   input wire rst_n,
   input wire [15:0] struct_version,
   input wire refresh,
   input wire [16*`HARB_CHIPS-1:0] spare_init,
   input wire [16*`HARB_CHIPS-1:0] spare_cur,
   input wire [31:0] erase_max_blk,
   input wire [31:0] erase_target,
   input wire [47:0] erase_total,
   input wire [31:0] ecc_total_cnt,
   input wire [31:0] ecc_corr_cnt,
   input wire [31:0] read_cnt,
   input wire [31:0] crc_cnt,
   input wire [7:0] spare_thresh,
   input wire [7:0] erase_thresh,
   input wire rec_rd,
   input wire [2:0] rec_slot,
   input wire [3:0] rec_idx,
   input wire stat_req,
   output wire busy,
   output reg rec_valid_q,
   output reg [7:0] rec_byte_q,
   output reg stat_valid_q,
   output reg [7:0] cyl_low_q,
   output reg [7:0] cyl_high_q,
   output wire thr_exceeded,
   output reg [7:0] spare_val_q,
   output reg [7:0] erase_val_q
);
   // ------------------------------------------------------------
   // States of the refresh sequencer
   // ------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_CHIP = 3'h1;
   localparam [2:0] ST_CHIP_W = 3'h2;
   localparam [2:0] ST_ERASE = 3'h3;
   localparam [2:0] ST_ERASE_W = 3'h4;

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [`HARB_CHIP_W-1:0] chip_q;
   reg [`HARB_CHIP_W-1:0] chip_d;
   reg [7:0] min_pct_q;
   reg [7:0] min_pct_d;
   reg [7:0] spare_val_d;
   reg [7:0] erase_val_d;
   reg [7:0] spare_worst_q;
   reg [7:0] erase_worst_q;
   reg div_start;
   reg [31:0] div_num;
   reg [31:0] div_den;
   reg [7:0] byte_d;
   reg [7:0] life;
   reg later;
   reg [3:0] off;
   wire div_done;
   wire [7:0] div_pct;
   wire [15:0] low_init;
   wire [15:0] low_cur;
   wire [15:0] sum_cur;
   wire last_chip;
   wire [15:0] flags_adv;
   wire [15:0] flags_pf;
   wire [47:0] spare_fields;
   wire [7:0] cnt_id;
   wire [31:0] cnt_word;

   // ------------------------------------------------------------
   // Little-endian byte pick from a field
   // ------------------------------------------------------------
   function [7:0] le_byte;
      input [47:0] field;
      input [3:0] n;
      reg [47:0] sh;
      begin
         sh = field >> {n, 3'b000};
         le_byte = sh[7:0];
      end
   endfunction

   // ------------------------------------------------------------
   // Layout selection from the reported structure version
   // ------------------------------------------------------------
   always @* begin
      later = (struct_version == `HARB_VER_LATER);
   end

   // ------------------------------------------------------------
   // Submodules
   // ------------------------------------------------------------
   harb_pct_div u_div (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .start(div_start),
      .num(div_num),
      .den(div_den),
      .busy(),
      .done(div_done),
      .pct(div_pct)
   );

   harb_spare_scan u_scan (
      .init_flat(spare_init),
      .cur_flat(spare_cur),
      .low_init(low_init),
      .low_cur(low_cur),
      .sum_cur(sum_cur)
   );

   // Chip count is a full power of two, so the last chip is all ones
   assign last_chip = (chip_q == {`HARB_CHIP_W{1'b1}});
   assign busy = (state_q != ST_IDLE);
   assign flags_adv = `HARB_FLAGS_ADVISORY;
   assign flags_pf = `HARB_FLAGS_PREFAIL;
   assign spare_fields = {sum_cur, low_cur, low_init};
   assign cnt_id = (rec_slot == `HARB_SLOT_ECC_TOT) ? `HARB_ID_ECC_TOT :
      (rec_slot == `HARB_SLOT_ECC_COR) ? `HARB_ID_ECC_COR :
      (rec_slot == `HARB_SLOT_READS) ? `HARB_ID_READS :
      `HARB_ID_CRC;
   assign cnt_word = (rec_slot == `HARB_SLOT_ECC_TOT) ? ecc_total_cnt :
      (rec_slot == `HARB_SLOT_ECC_COR) ? ecc_corr_cnt :
      (rec_slot == `HARB_SLOT_READS) ? read_cnt : crc_cnt;

   // ------------------------------------------------------------
   // Divider operand selection
   // ------------------------------------------------------------
   always @* begin
      if (state_q == ST_ERASE) begin
         div_num = erase_max_blk;
         div_den = erase_target;
      end else begin
         div_num = {16'h0000, spare_cur[chip_q*16 +: 16]};
         div_den = {16'h0000, spare_init[chip_q*16 +: 16]};
      end
   end

   // ------------------------------------------------------------
   // Remaining life from the share of target erases used
   // ------------------------------------------------------------
   always @* begin
      if (div_pct >= `HARB_PCT_FULL)
         life = 8'h00;
      else
         life = `HARB_PCT_FULL - div_pct;
   end

   // ------------------------------------------------------------
   // Refresh sequencer: chips one by one, then the erase estimate
   // ------------------------------------------------------------
   always @* begin
      state_d = state_q;
      chip_d = chip_q;
      min_pct_d = min_pct_q;
      spare_val_d = spare_val_q;
      erase_val_d = erase_val_q;
      div_start = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (refresh) begin
               chip_d = {`HARB_CHIP_W{1'b0}};
               min_pct_d = `HARB_PCT_FULL;
               state_d = ST_CHIP;
            end
         end
         ST_CHIP: begin
            div_start = 1'b1;
            state_d = ST_CHIP_W;
         end
         ST_CHIP_W: begin
            if (div_done) begin
               if (div_pct < min_pct_q)
                  min_pct_d = div_pct;
               if (last_chip) begin
                  spare_val_d = (div_pct < min_pct_q) ?
                     div_pct : min_pct_q;
                  state_d = ST_ERASE;
               end else begin
                  chip_d = chip_q + 1'b1;
                  state_d = ST_CHIP;
               end
            end
         end
         ST_ERASE: begin
            div_start = 1'b1;
            state_d = ST_ERASE_W;
         end
         ST_ERASE_W: begin
            if (div_done) begin
               erase_val_d = life;
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         chip_q <= {`HARB_CHIP_W{1'b0}};
         min_pct_q <= `HARB_PCT_FULL;
         spare_val_q <= `HARB_VALUE_RESET;
         erase_val_q <= `HARB_VALUE_RESET;
      end else begin
         state_q <= state_d;
         chip_q <= chip_d;
         min_pct_q <= min_pct_d;
         spare_val_q <= spare_val_d;
         erase_val_q <= erase_val_d;
      end
   end

   // ------------------------------------------------------------
   // Worst values: lowest value seen since reset
   // ------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         spare_worst_q <= `HARB_WORST_RESET;
         erase_worst_q <= `HARB_WORST_RESET;
      end else begin
         if (spare_val_q < spare_worst_q)
            spare_worst_q <= spare_val_q;
         if (erase_val_q < erase_worst_q)
            erase_worst_q <= erase_val_q;
      end
   end

   // ------------------------------------------------------------
   // Threshold check; the counter records take no part in it
   // ------------------------------------------------------------
   assign thr_exceeded = (spare_val_q < spare_thresh) ||
                         (erase_val_q < erase_thresh);

   // ------------------------------------------------------------
   // Record byte selection
   // ------------------------------------------------------------
   always @* begin
      byte_d = 8'h00;
      // Offset of a byte within the field that starts after the values
      off = later ? rec_idx - 4'h5 : rec_idx - 4'h4;
      if (rec_idx < `HARB_REC_LEN) begin
         case (rec_slot)
            `HARB_SLOT_SPARE: begin
               if (later) begin
                  case (rec_idx)
                     4'h0: byte_d = `HARB_ID_SPARE;
                     4'h1: byte_d = flags_pf[7:0];
                     4'h2: byte_d = flags_pf[15:8];
                     4'h3: byte_d = spare_val_q;
                     4'h4: byte_d = spare_worst_q;
                     4'hB: byte_d = 8'h00;
                     default: byte_d = le_byte(spare_fields, off);
                  endcase
               end
            end
            `HARB_SLOT_ERASE: begin
               case (rec_idx)
                  4'h0: byte_d = `HARB_ID_ERASE;
                  4'h1: byte_d = flags_adv[7:0];
                  4'h2: byte_d = flags_adv[15:8];
                  4'h3: byte_d = erase_val_q;
                  default: begin
                     if (later && rec_idx == 4'h4)
                        byte_d = erase_worst_q;
                     else if (later && rec_idx == 4'hB)
                        byte_d = 8'h00;
                     else
                        byte_d = le_byte(erase_total, off);
                  end
               endcase
            end
            `HARB_SLOT_ECC_TOT, `HARB_SLOT_ECC_COR,
            `HARB_SLOT_READS, `HARB_SLOT_CRC: begin
               case (rec_idx)
                  4'h0: byte_d = cnt_id;
                  4'h1: byte_d = flags_adv[7:0];
                  4'h2: byte_d = flags_adv[15:8];
                  4'h3: byte_d = `HARB_FIXED_VALUE;
                  default: begin
                     if (later && rec_idx == 4'h4)
                        byte_d = `HARB_FIXED_VALUE;
                     else if (off < 4'h4)
                        byte_d = le_byte({16'h0000, cnt_word}, off);
                     else
                        byte_d = 8'h00;
                  end
               endcase
            end
            default: byte_d = 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Record read port: one byte, one cycle after the request
   // ------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rec_valid_q <= 1'b0;
         rec_byte_q <= 8'h00;
      end else begin
         rec_valid_q <= rec_rd;
         if (rec_rd)
            rec_byte_q <= byte_d;
      end
   end

   // ------------------------------------------------------------
   // Status check answer
   // ------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_valid_q <= 1'b0;
         cyl_low_q <= `HARB_CYL_LO_OK;
         cyl_high_q <= `HARB_CYL_HI_OK;
      end else begin
         stat_valid_q <= stat_req;
         if (stat_req) begin
            if (thr_exceeded) begin
               cyl_low_q <= `HARB_CYL_LO_BAD;
               cyl_high_q <= `HARB_CYL_HI_BAD;
            end else begin
               cyl_low_q <= `HARB_CYL_LO_OK;
               cyl_high_q <= `HARB_CYL_HI_OK;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/harb_host.sv
/* Host model reading one attribute record, indices 0..15 back to back.
   Assumes the builder answers each read exactly one clock later. */
`timescale 1ns/1ps
`default_nettype none
module harb_host (
   input wire logic sys_clk,
   input wire logic rec_valid_q,
   input wire logic [7:0] rec_byte_q,
   output logic rec_rd,
   output logic [2:0] rec_slot,
   output logic [3:0] rec_idx
);
   initial begin
      rec_rd = 1'b0;
      rec_slot = 3'h0;
      rec_idx = 4'h0;
   end
   task automatic read_rec(input logic [2:0] s, output logic [127:0] q);
      int i;
      for (i = 0; i < 17; i++) begin
         @(posedge sys_clk);
         rec_rd <= (i < 16);
         rec_slot <= (i < 16) ? s : ~s;
         rec_idx <= i[3:0];
         #1;
         if (i > 0) begin
            q[8*(i-1)+:8] = rec_valid_q ? rec_byte_q : 8'hXX;
         end
      end
   endtask
endmodule
`default_nettype wire

// ### sim/harb_builder_sva.sv
/* Checker for record, status and refresh timing of the builder.
   Assumes it is bound to harb_builder. */
`timescale 1ns/1ps
`default_nettype none
module harb_builder_sva (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic refresh,
   input wire logic rec_rd,
   input wire logic [2:0] rec_slot,
   input wire logic [3:0] rec_idx,
   input wire logic stat_req,
   input wire logic [7:0] spare_thresh,
   input wire logic [7:0] erase_thresh,
   input wire logic busy,
   input wire logic rec_valid_q,
   input wire logic [7:0] rec_byte_q,
   input wire logic stat_valid_q,
   input wire logic [7:0] cyl_low_q,
   input wire logic [7:0] cyl_high_q,
   input wire logic thr_exceeded,
   input wire logic [7:0] spare_val_q,
   input wire logic [7:0] erase_val_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_bad_check;
      stat_req && thr_exceeded;
   endsequence
   sequence s_pulse;
      stat_valid_q ##1 !stat_valid_q;
   endsequence
   rec_answer_a: assert property (rec_rd |=> rec_valid_q)
      else $error("record answer missing");
   erase_id_a: assert property (rec_rd && rec_slot == 3'h1 &&
      rec_idx == 4'h0 |=> rec_byte_q == 8'hE5) else $error("erase id");
   fixed_value_a: assert property (rec_rd && rec_slot > 3'h1 &&
      rec_slot < 3'h6 && rec_idx == 4'h3 |=> rec_byte_q == 8'h64)
      else $error("fixed value");
   rec_bound_a: assert property (rec_rd && rec_idx > 4'hB
      |=> rec_byte_q == 8'h00) else $error("byte past record");
   stat_bad_a: assert property (s_bad_check |=> cyl_low_q == 8'hF4
      && cyl_high_q == 8'h2C) else $error("exceeded codes");
   stat_ok_a: assert property (stat_req && !thr_exceeded
      |=> cyl_low_q == 8'h4F && cyl_high_q == 8'hC2) else $error("ok codes");
   stat_pulse_a: assert property (stat_req ##1 !stat_req |-> s_pulse)
      else $error("status pulse");
   thr_flag_a: assert property (thr_exceeded == (spare_val_q <
      spare_thresh || erase_val_q < erase_thresh)) else $error("thr flag");
   refresh_end_a: assert property (refresh && !busy |=>
      busy ##[1:400] !busy) else $error("refresh length");
endmodule
`default_nettype wire

// ### sim/harb_builder_test.sv
/* Self-checking bench for harb_builder against an integer model.
   Assumes hw/ on the include path and harb_host as the reading host. */
`timescale 1ns/1ps
`default_nettype none
module harb_builder_test;
   logic sys_clk, rst_n, refresh, stat_req, rec_rd, rv, sval, busy, thr;
   logic [15:0] ver, r, li, lc, sum;
   logic [63:0] si, sc;
   logic [31:0] em, etg, cnt [4];
   logic [47:0] etot;
   logic [7:0] st, et, sv, ev, sw, ew, rb, cl, ch, spv, erv;
   logic [2:0] slot;
   logic [3:0] idx;
   logic [127:0] got;
   int n_errors, n_compared, k, c, v, s, i, x;
   harb_builder i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .struct_version(ver), .refresh(refresh), .spare_init(si),
      .spare_cur(sc), .erase_max_blk(em), .erase_target(etg),
      .erase_total(etot), .ecc_total_cnt(cnt[0]), .ecc_corr_cnt(cnt[1]),
      .read_cnt(cnt[2]), .crc_cnt(cnt[3]), .spare_thresh(st),
      .erase_thresh(et), .rec_rd(rec_rd), .rec_slot(slot), .rec_idx(idx),
      .stat_req(stat_req), .busy(busy), .rec_valid_q(rv),
      .rec_byte_q(rb), .stat_valid_q(sval), .cyl_low_q(cl),
      .cyl_high_q(ch), .thr_exceeded(thr), .spare_val_q(spv),
      .erase_val_q(erv));
   harb_host i_host (.sys_clk(sys_clk), .rec_valid_q(rv),
      .rec_byte_q(rb), .rec_rd(rec_rd), .rec_slot(slot), .rec_idx(idx));
   function logic [15:0] rnd();
      r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
      return r;
   endfunction
   task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task end_sim();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [7:0] e_byte(int s, int i, bit lat);
      logic [95:0] q;
      logic [7:0] id;
      id = (s == 2) ? 8'hCB : (s == 3) ? 8'hCC : (s == 4) ? 8'hE8 : 8'hC7;
      q = 96'h0;
      if (s == 1 && lat) q = {8'h00, etot, ew, ev, 16'h0002, 8'hE5};
      else if (s == 1) q = {16'h0000, etot, ev, 16'h0002, 8'hE5};
      else if (s == 0 && lat) q = {8'h00, sum, lc, li, sw, sv, 16'h0003, 8'hC4};
      else if (s > 1 && s < 6 && lat)
         q = {24'h0, cnt[s-2], 16'h6464, 16'h0002, id};
      else if (s > 1 && s < 6) q = {32'h0, cnt[s-2], 8'h64, 16'h0002, id};
      return (i < 12) ? q[8*i+:8] : 8'h00;
   endfunction
   task model();
      int ic, cc, p, t;
      sv = 8'h64;
      t = 0;
      for (int c = 0; c < 4; c++) begin
         ic = si[16*c+:16];
         cc = sc[16*c+:16];
         p = (ic == 0 || cc >= ic) ? 100 : 100 * cc / ic;
         if (p < sv) sv = p;
         if (c == 0 || cc < lc) begin
            lc = cc;
            li = ic;
         end
         t += cc;
      end
      sum = (t > 65535) ? 16'hFFFF : t;
      p = 100 * em / etg;
      ev = (p > 100) ? 0 : 100 - p;
      if (sv < sw) sw = sv;
      if (ev < ew) ew = ev;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      #100000;
      n_errors++;
      end_sim();
   end
   initial begin
      {rst_n, refresh, stat_req, si, sc, em, etot, st, et} = 0;
      foreach (cnt[c]) cnt[c] = 32'h0;
      ver = 16'h0004;
      etg = 32'h1;
      r = 16'h005B;
      sw = 8'h64;
      ew = 8'h64;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (k = 0; k < 2; k++) begin
         @(posedge sys_clk);
         for (c = 0; c < 4; c++) begin
            x = rnd() | 16'h0001;
            si[16*c+:16] <= x;
            sc[16*c+:16] <= rnd() % (x + 1);
            cnt[c] <= {rnd(), rnd()};
         end
         x = rnd() | 16'h0001;
         etg <= x;
         em <= rnd() % (x + x / 4);
         etot <= {rnd(), rnd(), rnd()};
         st <= 8'h00;
         et <= 8'h00;
         @(posedge sys_clk);
         refresh <= 1'b1;
         @(posedge sys_clk);
         refresh <= 1'b0;
         model();
         #1;
         for (c = 0; c < 1000 && busy !== 1'b0; c++) begin
            @(posedge sys_clk);
            #1;
         end
         chk("spare value", sv, spv);
         chk("erase value", ev, erv);
         for (v = 0; v < 2; v++) begin
            @(posedge sys_clk);
            ver <= v ? 16'h0010 : 16'h0004;
            for (s = 0; s < 8; s++) begin
               i_host.read_rec(s[2:0], got);
               for (i = 0; i < 16; i++)
                  chk("record byte", e_byte(s, i, v), got[8*i+:8]);
            end
         end
         for (c = 0; c < 4; c++) begin
            @(posedge sys_clk);
            st <= sv + c[0];
            et <= ev + c[1];
            @(posedge sys_clk);
            stat_req <= 1'b1;
            @(posedge sys_clk);
            stat_req <= 1'b0;
            #1;
            chk("cyl low", (c != 0) ? 8'hF4 : 8'h4F, cl);
            chk("cyl high", (c != 0) ? 8'h2C : 8'hC2, ch);
            chk("stat valid", 1'b1, sval);
            chk("thr flag", c != 0, thr);
         end
      end
      end_sim();
   end
endmodule
bind harb_builder harb_builder_sva i_sva (.sys_clk(sys_clk), .rst_n(rst_n),
   .refresh(refresh), .rec_rd(rec_rd), .rec_slot(rec_slot),
   .rec_idx(rec_idx), .stat_req(stat_req), .spare_thresh(spare_thresh),
   .erase_thresh(erase_thresh), .busy(busy), .rec_valid_q(rec_valid_q),
   .rec_byte_q(rec_byte_q), .stat_valid_q(stat_valid_q),
   .cyl_low_q(cyl_low_q), .cyl_high_q(cyl_high_q),
   .thr_exceeded(thr_exceeded), .spare_val_q(spare_val_q),
   .erase_val_q(erase_val_q));
`default_nettype wire
